//--- logic/lpwc_regs.svh
// Constants of the low-power mode and wakeup controller.
// Assumes a 40 MHz system clock; included by the controller files.
`ifndef LPWC_REGS_SVH
`define LPWC_REGS_SVH
`define LPWC_CLK_MHZ        40
`define LPWC_STOP_EXIT_NS   3500
`define LPWC_SBY_EXIT_NS    60000
`define LPWC_STOP_EXIT_CYC  ((`LPWC_STOP_EXIT_NS * `LPWC_CLK_MHZ) / 1000)
`define LPWC_SBY_EXIT_CYC   ((`LPWC_SBY_EXIT_NS * `LPWC_CLK_MHZ) / 1000)
`define LPWC_N_PINS         3
`define LPWC_N_LINES        8
`define LPWC_CNT_W          12
`endif

//--- logic/lpwc_pkg.sv
// Types of the low-power mode and wakeup controller.
// Assumes nothing beyond the constants header.
package lpwc_pkg;
  typedef enum logic [2:0] {
    LPWC_RUN      = 3'b000,
    LPWC_STOP     = 3'b001,
    LPWC_SBY_CLK  = 3'b010,
    LPWC_SBY_NCLK = 3'b011,
    LPWC_EXIT     = 3'b100
  } lpwc_state_e;
endpackage : lpwc_pkg

//--- logic/lpwc_wake_latch.sv
// Always-on wakeup latch: edge detect and sticky hold of wakeup sources.
// Assumes synchronous inputs; cleared only once the exit sequence starts.
`timescale 1ns/1ps
`include "lpwc_regs.svh"
module lpwc_wake_latch #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Sources and control
  input  wire logic [W-1:0] i_src,
  input  wire logic [W-1:0] i_edge_mode,
  input  wire logic         i_arm,
  input  wire logic         i_clr,
  // Latched request
  output logic      [W-1:0] o_pend
);
  logic [W-1:0] prev_q;
  logic [W-1:0] hit;

  // Rising edge or level per source
  assign hit = i_edge_mode & i_src & ~prev_q | ~i_edge_mode & i_src;

  // Sticky pending; a new hit beats the clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      prev_q <= '0;
      o_pend <= '0;
    end else begin
      prev_q <= i_src;
      o_pend <= (i_clr ? '0 : o_pend) | (i_arm ? hit : '0);
    end
  end
endmodule : lpwc_wake_latch

//--- logic/lpwc_ctrl.sv
// Low-power mode controller: stop, standby with and without clock, exit.
// Assumes synchronous inputs and a core that requests modes by pulses.
`timescale 1ns/1ps
`include "lpwc_regs.svh"
module lpwc_ctrl
  import lpwc_pkg::*;
#(
  parameter int N_PERIPH  = 4,
  parameter int STOP_CYC  = `LPWC_STOP_EXIT_CYC,
  parameter int SBY_CYC   = `LPWC_SBY_EXIT_CYC
) (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  // Core mode requests
  input  wire logic                      i_stop_req,
  input  wire logic                      i_sby_req,
  input  wire logic                      i_sby_keep_rtc,
  // Stop wakeup sources
  input  wire logic [`LPWC_N_LINES-1:0]  i_external_event_lines,
  input  wire logic                      i_supply_voltage_detector,
  input  wire logic [1:0]                i_analog_comparator,
  input  wire logic                      i_vref_on,
  input  wire logic                      i_serial_start_bit,
  input  wire logic                      i_serial_frame_wake,
  input  wire logic                      i_twowire_addr_match,
  input  wire logic                      i_low_power_timer_wake,
  // Standby wakeup sources
  input  wire logic                      i_external_reset_pin,
  input  wire logic                      i_independent_watchdog_rst,
  input  wire logic [`LPWC_N_PINS-1:0]   i_wakeup_pin,
  input  wire logic [4:0]                i_rtc_event,
  // Fast oscillator requests by peripherals
  input  wire logic [N_PERIPH-1:0]       i_fosc_req,
  // Power and clock controls
  output logic                           o_core_clk_en,
  output logic                           o_core_pwr_on,
  output logic                           o_pll_en,
  output logic                           o_fast_internal_osc_en,
  output logic                           o_fast_crystal_osc_en,
  output logic                           o_multispeed_internal_osc_en,
  output logic                           o_low_speed_osc_en,
  output logic [N_PERIPH-1:0]            o_fosc_gate,
  output logic                           o_cmp_gptim_link_en,
  output logic                           o_cmp_low_power_timer_unit_link_en,
  output logic                           o_tim_tim_link_en,
  output logic                           o_wake_irq,
  output logic                           o_state_lost,
  output logic [2:0]                     o_mode
);
  localparam int NS = `LPWC_N_LINES + 8;
  localparam int NB = 2 + `LPWC_N_PINS + 5;

  lpwc_state_e          state_q, state_d;
  logic [`LPWC_CNT_W-1:0] cnt_q;
  logic [NS-1:0]        stop_src, stop_pend;
  logic [NB-1:0]        sby_src, sby_edge, sby_pend;
  logic [NB-1:0]        sby_allow;
  logic                 in_stop, in_sby, in_sby_clk, stop_wake, sby_wake;
  logic                 exit_start, lost_q;

  // Stop sources; comparators count only with the reference on
  assign stop_src = {i_external_event_lines, i_supply_voltage_detector,
    i_analog_comparator & {2{i_vref_on}}, i_serial_start_bit,
    i_serial_frame_wake, i_twowire_addr_match, i_low_power_timer_wake,
    1'b0};
  // Standby sources: reset and watchdog as levels, pins and clock as edges
  assign sby_src   = {i_external_reset_pin, i_independent_watchdog_rst,
                      i_wakeup_pin, i_rtc_event};
  assign sby_edge  = {2'b00, {`LPWC_N_PINS{1'b1}}, 5'h1F};
  // Without the kept clock only reset pin and wakeup pins may exit
  assign sby_allow = in_sby_clk ? {NB{1'b1}}
                   : {1'b1, 1'b0, {`LPWC_N_PINS{1'b1}}, 5'h00};

  assign in_stop    = state_q == LPWC_STOP;
  assign in_sby_clk = state_q == LPWC_SBY_CLK;
  assign in_sby     = in_sby_clk | (state_q == LPWC_SBY_NCLK);
  assign stop_wake  = in_stop & |stop_pend;
  assign sby_wake   = in_sby & |(sby_pend & sby_allow);
  assign exit_start = state_q == LPWC_EXIT;

  // Always-on wakeup latches
  lpwc_wake_latch #(.W(NS)) u_stop_latch (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_src       (stop_src),
    .i_edge_mode ({NS{1'b0}}),
    .i_arm       (in_stop),
    .i_clr       (exit_start),
    .o_pend      (stop_pend)
  );
  lpwc_wake_latch #(.W(NB)) u_sby_latch (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_src       (sby_src),
    .i_edge_mode (sby_edge),
    .i_arm       (in_sby),
    .i_clr       (exit_start),
    .o_pend      (sby_pend)
  );

  // Mode sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LPWC_RUN: begin
        if (i_sby_req) begin
          state_d = i_sby_keep_rtc ? LPWC_SBY_CLK : LPWC_SBY_NCLK;
        end else if (i_stop_req) begin
          state_d = LPWC_STOP;
        end
      end
      LPWC_STOP:     if (stop_wake) state_d = LPWC_EXIT;
      LPWC_SBY_CLK,
      LPWC_SBY_NCLK: if (sby_wake) state_d = LPWC_EXIT;
      LPWC_EXIT:     if (cnt_q == '0) state_d = LPWC_RUN;
      default:       state_d = LPWC_RUN;
    endcase
  end

  // State, exit countdown and outputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= LPWC_RUN;
      cnt_q   <= '0;
      lost_q  <= 1'b0;
      o_wake_irq <= 1'b0;
    end else begin
      state_q <= state_d;
      o_wake_irq <= stop_wake | sby_wake;
      if (stop_wake) begin
        cnt_q <= `LPWC_CNT_W'(STOP_CYC - 2);
      end else if (sby_wake) begin
        cnt_q <= `LPWC_CNT_W'(SBY_CYC - 2);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
      if (state_d == LPWC_SBY_CLK || state_d == LPWC_SBY_NCLK) begin
        lost_q <= 1'b1;
      end else if (state_d == LPWC_RUN) begin
        lost_q <= 1'b0;
      end
    end
  end

  // Clock and power controls follow the next state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_core_clk_en   <= 1'b1;
      o_core_pwr_on   <= 1'b1;
      o_pll_en        <= 1'b1;
      o_fast_crystal_osc_en        <= 1'b1;
      o_multispeed_internal_osc_en <= 1'b1;
      o_fast_internal_osc_en       <= 1'b1;
      o_low_speed_osc_en  <= 1'b1;
      o_fosc_gate     <= '1;
      o_cmp_gptim_link_en <= 1'b1;
      o_cmp_low_power_timer_unit_link_en <= 1'b1;
      o_tim_tim_link_en   <= 1'b1;
      o_state_lost    <= 1'b0;
      o_mode          <= LPWC_RUN;
    end else begin
      o_core_clk_en   <= state_d == LPWC_RUN;
      o_core_pwr_on   <= !(state_d == LPWC_SBY_CLK ||
                           state_d == LPWC_SBY_NCLK);
      o_pll_en        <= state_d == LPWC_RUN;
      o_fast_crystal_osc_en        <= state_d == LPWC_RUN;
      o_multispeed_internal_osc_en <= state_d == LPWC_RUN;
      // Fast osc in stop only while a peripheral asks
      o_fast_internal_osc_en <= state_d == LPWC_RUN ||
        (state_d == LPWC_STOP && |i_fosc_req);
      o_fosc_gate     <= (state_d == LPWC_STOP) ? i_fosc_req
                       : (state_d == LPWC_RUN) ? '1 : '0;
      // Slow osc kept for the clock and watchdog
      o_low_speed_osc_en <= state_d != LPWC_SBY_NCLK;
      o_cmp_low_power_timer_unit_link_en <= !(state_d == LPWC_SBY_CLK ||
                               state_d == LPWC_SBY_NCLK);
      o_cmp_gptim_link_en <= state_d == LPWC_RUN ||
                             state_d == LPWC_EXIT;
      o_tim_tim_link_en   <= state_d == LPWC_RUN ||
                             state_d == LPWC_EXIT;
      o_state_lost    <= lost_q;
      o_mode          <= state_d;
    end
  end

  // Assertions
  int unsigned wait_q;
  logic        from_stop_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || state_q != LPWC_EXIT) wait_q <= 0;
    else wait_q <= wait_q + 1;
  end
  // Remembers whether the running exit left stop or standby
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      from_stop_q <= 1'b0;
    end else if (stop_wake) begin
      from_stop_q <= 1'b1;
    end else if (sby_wake) begin
      from_stop_q <= 1'b0;
    end
  end
  // One cycle goes from latch to exit, so the exit state gets one less
  a_stop_exit_time: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exit_start && from_stop_q |-> wait_q < STOP_CYC - 1)
    else $error("stop exit too slow");
  a_sby_exit_time: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exit_start && !from_stop_q |-> wait_q < SBY_CYC - 1)
    else $error("standby exit too slow");
  a_stop_wake_go: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    stop_wake |=> state_q == LPWC_EXIT) else $error("stop wake lost");
  a_stop_clk_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_q == LPWC_STOP |-> !o_core_clk_en && !o_pll_en)
    else $error("clock runs in stop");
  a_fosc_only_req: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(state_d) == LPWC_STOP && $past(i_rst_n) |->
    o_fosc_gate == $past(i_fosc_req))
    else $error("fast osc gate wrong");
  a_sby_pwr_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    in_sby |-> !o_core_pwr_on) else $error("core powered");
  a_sby_slow_osc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    in_sby_clk |-> o_low_speed_osc_en && !o_fast_crystal_osc_en)
    else $error("osc wrong in standby");
  a_nclk_no_rtc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_q == LPWC_SBY_NCLK && !(|(sby_pend & sby_allow)) |=>
    state_q == LPWC_SBY_NCLK) else $error("bad standby exit");
  a_link_stop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    in_stop |-> o_cmp_low_power_timer_unit_link_en && !o_tim_tim_link_en)
    else $error("link state wrong");
  a_pend_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    |stop_pend && !exit_start |=> |stop_pend)
    else $error("wake lost");
  c_stop_cycle: cover property (@(posedge i_clk) in_stop ##1 exit_start);
  c_sby_clk:    cover property (@(posedge i_clk) in_sby_clk ##1 exit_start);
  c_sby_nclk:   cover property (@(posedge i_clk)
    state_q == LPWC_SBY_NCLK ##1 exit_start);
  c_fosc_req:   cover property (@(posedge i_clk) in_stop && |i_fosc_req);
endmodule : lpwc_ctrl

//--- bench/lpwc_periph_model.sv
// Wakeup-capable peripheral model asking for the fast internal osc.
// Assumes a go pulse from the bench; holds the request HOLD+1 cycles.
`timescale 1ns/1ps
module lpwc_periph_model #(
  parameter int HOLD = 6
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Command from the bench
  input  wire logic       i_go,
  input  wire logic [1:0] i_idx,
  // Oscillator requests
  output logic      [3:0] o_req
);
  logic [7:0] cnt_q;
  // Raise one request, drop it once the count runs out
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
      o_req <= 4'h0;
    end else if (i_go) begin
      cnt_q <= 8'(HOLD);
      o_req <= 4'h1 << i_idx;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else begin
      o_req <= 4'h0;
    end
  end
endmodule : lpwc_periph_model

//--- bench/lpwc_ctrl_tb.sv
// Bench of the low-power mode controller: stop, standby, wake sources.
// Assumes short exit counts set by parameters below.
`timescale 1ns/1ps
module lpwc_ctrl_tb;
  localparam int SC = 8;
  localparam int BC = 16;
  logic i_clk, i_rst_n, stop_q, sby_q, keep_q, vref, wdog, xrst, go;
  logic [7:0] ev;
  logic [4:0] sv, rtc;
  logic [1:0] cmp, idx;
  logic [3:0] req, gate;
  logic [2:0] o_mode, wk;
  logic [9:0] st;
  logic       irq, lost;
  int fails = 0;
  int samples_checked = 0;
  // Clock and initial values
  initial begin
    i_clk = 0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial {i_rst_n, stop_q, sby_q, keep_q, vref, wdog, xrst, go} = 8'h00;
  initial {ev, sv, rtc, cmp, idx, wk} = 25'h0;
  lpwc_periph_model #(.HOLD(6)) pm (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_go(go), .i_idx(idx), .o_req(req));
  lpwc_ctrl #(.STOP_CYC(SC), .SBY_CYC(BC)) dut (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_stop_req(stop_q), .i_sby_req(sby_q),
    .i_sby_keep_rtc(keep_q), .i_external_event_lines(ev),
    .i_supply_voltage_detector(sv[0]), .i_analog_comparator(cmp),
    .i_vref_on(vref), .i_serial_start_bit(sv[1]),
    .i_serial_frame_wake(sv[2]), .i_twowire_addr_match(sv[3]),
    .i_low_power_timer_wake(sv[4]), .i_external_reset_pin(xrst),
    .i_independent_watchdog_rst(wdog), .i_wakeup_pin(wk),
    .i_rtc_event(rtc), .i_fosc_req(req), .o_core_clk_en(st[9]),
    .o_core_pwr_on(st[8]), .o_pll_en(st[7]),
    .o_fast_internal_osc_en(st[6]), .o_fast_crystal_osc_en(st[5]),
    .o_multispeed_internal_osc_en(st[4]), .o_low_speed_osc_en(st[3]),
    .o_fosc_gate(gate), .o_cmp_gptim_link_en(st[2]),
    .o_cmp_low_power_timer_unit_link_en(st[1]), .o_tim_tim_link_en(st[0]),
    .o_wake_irq(irq), .o_state_lost(lost), .o_mode(o_mode));
  // Verdict and end of run
  task automatic stop_test;
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  // Bounded wait for a mode code
  task automatic wmode(input logic [2:0] m, input int n);
    int k;
    k = 0;
    while (o_mode !== m && k < n) begin
      cyc(1);
      k++;
    end
    chk(10'(o_mode), 10'(m));
    if (o_mode !== m) stop_test();
  endtask : wmode
  task automatic enter(input logic sb, kr, input logic [2:0] m,
                       input logic [9:0] e);
    @(posedge i_clk);
    {stop_q, sby_q, keep_q} <= {!sb, sb, kr};
    @(posedge i_clk);
    {stop_q, sby_q} <= 2'b00;
    wmode(m, 6);
    chk(st, e);
  endtask : enter
  task automatic leave(input int n, input logic ls);
    wmode(3'h4, 6);
    chk(10'(irq), 10'h001);
    chk(10'(lost), 10'(ls));
    wmode(3'h0, n + 1);
    // Lost flag trails the mode code by one cycle
    cyc(1);
    chk(10'(lost), 10'h000);
    chk(st, 10'h3FF);
    {ev, sv, rtc, cmp, vref, wdog, xrst, wk} <= 26'h0;
  endtask : leave
  // The five single stop sources and event line 7, each one alone
  task automatic t_stop_srcs;
    for (int i = 0; i < 6; i++) begin
      enter(0, 0, 3'h1, 10'h10A);
      if (i < 5) sv <= 5'h1 << i;
      else ev <= 8'h80;
      leave(SC, 0);
    end
  endtask : t_stop_srcs
  task automatic t_cmp_gate;
    enter(0, 0, 3'h1, 10'h10A);
    cmp <= 2'b10;
    cyc(6);
    chk(10'(o_mode), 10'h001);
    vref <= 1'b1;
    leave(SC, 0);
  endtask : t_cmp_gate
  task automatic t_fosc;
    enter(0, 0, 3'h1, 10'h10A);
    @(posedge i_clk);
    {go, idx} <= 3'b110;
    @(posedge i_clk);
    go <= 1'b0;
    cyc(2);
    chk(10'({st[6], gate}), 10'h014);
    cyc(8);
    chk(10'({st[6], gate}), 10'h000);
    ev <= 8'h01;
    leave(SC, 0);
  endtask : t_fosc
  task automatic t_sby;
    enter(1, 0, 3'h3, 10'h000);
    {wdog, rtc} <= 6'h3F;
    cyc(6);
    chk(10'(o_mode), 10'h003);
    xrst <= 1'b1;
    leave(BC, 1);
    enter(1, 1, 3'h2, 10'h008);
    rtc <= 5'h10;
    leave(BC, 1);
    // Rising wakeup pin ends standby without the clock
    enter(1, 0, 3'h3, 10'h000);
    wk <= 3'h4;
    leave(BC, 1);
  endtask : t_sby
  // Reset in mid-stop brings every output back to its reset level
  task automatic t_reset;
    enter(0, 0, 3'h1, 10'h10A);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    cyc(1);
    chk(st, 10'h3FF);
    chk({1'b0, gate, irq, lost, o_mode}, 10'h1E0);
  endtask : t_reset
  // Main sequence
  initial begin
    cyc(3);
    i_rst_n <= 1'b1;
    cyc(1);
    chk(st, 10'h3FF);
    chk({1'b0, gate, irq, lost, o_mode}, 10'h1E0);
    t_stop_srcs();
    t_cmp_gate();
    t_fosc();
    t_sby();
    t_reset();
    stop_test();
  end
endmodule : lpwc_ctrl_tb
